// file: core/debug_event_pkg.sv
// Shared constants and types for the debug event pins and board glue.
package debug_event_pkg;
  // Clock and test clock timing; the test clock period is a plain choice.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCK_PERIOD_NS = 100;
  localparam int PULSE_MIN_NS  = TCK_PERIOD_NS;
  localparam int PULSE_MAX_NS  = 10000;
  localparam int PULSE_NS      = 2000;
  localparam int PULSE_MIN_CYCLES =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES     = PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W      = 10;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD =
    PULSE_CNT_W'(PULSE_CYCLES - 1);

  // Event pin count and device counter width.
  localparam int PINS    = 2;
  localparam int COUNT_W = 16;

  // Register map of the glue logic, byte offsets on a 4-bit address.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] MASK_OFFSET   = 4'h8;
  localparam logic [3:0] LEVEL_OFFSET  = 4'hC;

  // Field positions.
  localparam int CTRL_GATE_BIT     = 0;
  localparam int STAT_PULSE_BASE   = 0;
  localparam int STAT_BLOCKED_BASE = 2;
  localparam int LEVEL_LINE_BASE   = 0;
  localparam int LEVEL_DRIVE_BASE  = 2;
  localparam int LEVEL_GATE_BIT    = 4;

  // Reset values.
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET   = 4'h0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIN_MODE_OFF,
    PIN_MODE_SIGNAL,
    PIN_MODE_COUNT
  } pin_mode_type;

  typedef enum logic [1:0] {
    PULSE_ARMED,
    PULSE_DRIVING,
    PULSE_WAIT_HIGH
  } pulse_state_type;
endpackage : debug_event_pkg

// file: core/debug_event_if.sv
// Board wiring between a processor's event pins and the board glue.
`timescale 1ns/10ps
`default_nettype none
interface debug_event_if;
  logic [1:0] dev_pin_out;
  logic [1:0] dev_pin_oe_n;
  logic [1:0] dev_pin_in;
  logic [1:0] bus_level;
  logic [1:0] return_out;
  logic [1:0] return_oe_n;
  logic [1:0] return_level;

  // Pull-ups make an undriven line read high.
  assign bus_level    = dev_pin_oe_n | dev_pin_out;
  assign return_level = return_oe_n | return_out;
  assign dev_pin_in   = (dev_pin_oe_n & return_level)
                      | (~dev_pin_oe_n & dev_pin_out);

  modport device (
    output dev_pin_out,
    output dev_pin_oe_n,
    input  dev_pin_in
  );
  modport glue (
    input  bus_level,
    output return_out,
    output return_oe_n
  );
endinterface : debug_event_if
`default_nettype wire

// file: core/debug_event_device.sv
// Processor end: debug event pin drivers, external count and halt.
`timescale 1ns/10ps
`default_nettype none
module debug_event_device (
  input  wire logic                          CLK,
  input  wire logic                          SYS_RST,
  debug_event_if.device                      EVT,
  input  wire debug_event_pkg::pin_mode_type PIN_MODE,
  input  wire logic                          BENCHMARK_RUN_COMMAND,
  input  wire logic                          HALT_ENABLE,
  input  wire logic [1:0]                    EVENT_REQUEST,
  input  wire logic                          EVENT_RELEASE,
  input  wire logic                          COUNT_TICK,
  input  wire logic                          RESUME,
  output logic                               HALTED
);
  logic [1:0]                         pin_meta;
  logic [1:0]                         pin_sync;
  logic [1:0]                         event_low;
  logic [1:0]                         next_event_low;
  logic [debug_event_pkg::COUNT_W-1:0] count;
  logic [debug_event_pkg::COUNT_W-1:0] next_count;
  logic                               next_carry;
  logic                               next_halted;
  logic [1:0]                         next_out;
  logic [1:0]                         next_oe_n;
  logic                               signal_mode;
  logic                               count_mode;

  assign count_mode  = (PIN_MODE == debug_event_pkg::PIN_MODE_COUNT)
                     | BENCHMARK_RUN_COMMAND;
  assign signal_mode = (PIN_MODE == debug_event_pkg::PIN_MODE_SIGNAL)
                     & ~count_mode;

  always_comb begin
    next_event_low = '0;
    next_count     = count;
    next_carry     = 1'b0;
    next_out       = '0;
    next_oe_n      = '1;
    if (signal_mode) begin
      next_event_low = (event_low & ~{2{EVENT_RELEASE}}) | EVENT_REQUEST;
    end
    if (count_mode && COUNT_TICK && !HALTED) begin
      next_count = count + 1'b1;
      next_carry = &count;
    end
    next_halted = (HALT_ENABLE & signal_mode & ~(&pin_sync))
                | (HALTED & ~RESUME);
    if (count_mode) begin
      next_oe_n = 2'h0;
      next_out  = {next_carry, next_halted};
    end else if (signal_mode) begin
      next_oe_n = ~next_event_low;
      next_out  = 2'h0;
    end else begin
      next_oe_n = 2'h3;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_meta         <= 2'h3;
      pin_sync         <= 2'h3;
      event_low        <= 2'h0;
      count            <= '0;
      HALTED           <= 1'b0;
      EVT.dev_pin_out  <= 2'h0;
      EVT.dev_pin_oe_n <= 2'h3;
    end else begin
      pin_meta         <= EVT.dev_pin_in;
      pin_sync         <= pin_meta;
      event_low        <= next_event_low;
      count            <= next_count;
      HALTED           <= next_halted;
      EVT.dev_pin_out  <= next_out;
      EVT.dev_pin_oe_n <= next_oe_n;
    end
  end
endmodule : debug_event_device
`default_nettype wire

// file: core/debug_event_glue.sv
// Board glue: event return pulse generator with AXI4-Lite registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Idle event pins stay high impedance.
// - Signal mode pulls pins low, open-collector.
// - External drivers only through open collectors.
// - Count mode drives push-pull, one device.
// - External sources idle during any count.
// - Enabled device halts on low pin, in signal mode only.
// - Count mode: pin1 carry, pin0 halted.
// - Board edge splits event in and out.
// - Low bus line yields low return pulse.
// - Pulse above one TCK, under limit.
// - Count gate holds return line high.
// - Software returns event pin high.
// - Slow lines ANDed into one signal.
module debug_event_glue (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  debug_event_if.glue      EVT,
  input  wire logic        EXT_COUNT_ACTIVE_GATE,
  input  wire logic [1:0]  PEER_EVENT,
  output logic [1:0]       EMULATOR_EVENT,
  output logic             IRQ,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  logic [1:0]  line_meta;
  logic [1:0]  line_sync;
  logic [1:0]  peer_meta;
  logic [1:0]  peer_sync;
  logic        gate_meta;
  logic        gate_sync;
  logic        gate;
  logic [1:0]  pulse_start;
  logic [1:0]  pulse_blocked;
  logic [1:0]  driving;
  logic [3:0]  ctrl;
  logic [3:0]  next_ctrl;
  logic [3:0]  status;
  logic [3:0]  next_status;
  logic [3:0]  mask;
  logic [3:0]  next_mask;
  logic        aw_held;
  logic        next_aw_held;
  logic [3:0]  aw_addr;
  logic [3:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [7:0]  w_byte;
  logic [7:0]  next_w_byte;
  logic        w_lane0;
  logic        next_w_lane0;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [3:0]  read_clear;

  // True when the offset names a register of the map.
  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr == debug_event_pkg::CTRL_OFFSET)
           | (addr == debug_event_pkg::STATUS_OFFSET)
           | (addr == debug_event_pkg::MASK_OFFSET)
           | (addr == debug_event_pkg::LEVEL_OFFSET);
  endfunction : mapped

  assign gate = gate_sync | ctrl[debug_event_pkg::CTRL_GATE_BIT];

  assign EVT.return_out = 2'h0;
  assign EVT.return_oe_n = ~driving;

  genvar ch;
  generate
    for (ch = 0; ch < debug_event_pkg::PINS; ch++) begin : g_chan
      debug_event_pkg::pulse_state_type state;
      debug_event_pkg::pulse_state_type next_state;
      logic [debug_event_pkg::PULSE_CNT_W-1:0] cnt;
      logic [debug_event_pkg::PULSE_CNT_W-1:0] next_cnt;

      always_comb begin
        next_state         = state;
        next_cnt           = cnt;
        pulse_start[ch]    = 1'b0;
        pulse_blocked[ch]  = 1'b0;
        case (state)
          debug_event_pkg::PULSE_ARMED: begin
            if (!line_sync[ch]) begin
              if (gate) begin
                pulse_blocked[ch] = 1'b1;
                next_state        = debug_event_pkg::PULSE_WAIT_HIGH;
              end else begin
                pulse_start[ch] = 1'b1;
                next_cnt        = debug_event_pkg::PULSE_LOAD;
                next_state      = debug_event_pkg::PULSE_DRIVING;
              end
            end
          end
          debug_event_pkg::PULSE_DRIVING: begin
            if (gate || cnt == '0) begin
              next_state = debug_event_pkg::PULSE_WAIT_HIGH;
            end else begin
              next_cnt = cnt - 1'b1;
            end
          end
          default: begin
            if (line_sync[ch]) begin
              next_state = debug_event_pkg::PULSE_ARMED;
            end
          end
        endcase
      end

      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          state       <= debug_event_pkg::PULSE_ARMED;
          cnt         <= '0;
          driving[ch] <= 1'b0;
        end else begin
          state       <= next_state;
          cnt         <= next_cnt;
          driving[ch] <= (next_state == debug_event_pkg::PULSE_DRIVING);
        end
      end
    end
  endgenerate

  assign S_AXI_AWREADY = ~aw_held;
  assign S_AXI_WREADY  = ~w_held;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = S_AXI_BVALID & ~S_AXI_BREADY;
    next_bresp   = S_AXI_BRESP;
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_rvalid  = S_AXI_RVALID & ~S_AXI_RREADY;
    next_rdata   = S_AXI_RDATA;
    next_rresp   = S_AXI_RRESP;
    read_clear   = 4'h0;
    if (S_AXI_AWVALID && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held) begin
      next_w_held  = 1'b1;
      next_w_byte  = S_AXI_WDATA[7:0];
      next_w_lane0 = S_AXI_WSTRB[0];
    end
    // Both halves held: commit once and raise the response in the same cycle.
    if (aw_held && w_held && !S_AXI_BVALID) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? debug_event_pkg::RESP_OKAY
                                     : debug_event_pkg::RESP_SLVERR;
      if (aw_addr == debug_event_pkg::CTRL_OFFSET && w_lane0) begin
        next_ctrl = w_byte[3:0];
      end else if (aw_addr == debug_event_pkg::MASK_OFFSET && w_lane0) begin
        next_mask = w_byte[3:0];
      end
    end
    if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0;
      next_rresp  = debug_event_pkg::RESP_OKAY;
      if (S_AXI_ARADDR == debug_event_pkg::CTRL_OFFSET) begin
        next_rdata[3:0] = ctrl;
      end else if (S_AXI_ARADDR == debug_event_pkg::STATUS_OFFSET) begin
        next_rdata[3:0] = status;
        read_clear      = status;
      end else if (S_AXI_ARADDR == debug_event_pkg::MASK_OFFSET) begin
        next_rdata[3:0] = mask;
      end else if (S_AXI_ARADDR == debug_event_pkg::LEVEL_OFFSET) begin
        next_rdata[debug_event_pkg::LEVEL_LINE_BASE +: 2]  = line_sync;
        next_rdata[debug_event_pkg::LEVEL_DRIVE_BASE +: 2] = driving;
        next_rdata[debug_event_pkg::LEVEL_GATE_BIT]        = gate;
      end else begin
        next_rresp = debug_event_pkg::RESP_SLVERR;
      end
    end
    // A new event in the clearing read's cycle survives the clear.
    next_status = (status & ~read_clear)
                | {pulse_blocked, pulse_start};
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      line_meta      <= 2'h3;
      line_sync      <= 2'h3;
      peer_meta      <= 2'h3;
      peer_sync      <= 2'h3;
      gate_meta      <= 1'b0;
      gate_sync      <= 1'b0;
      EMULATOR_EVENT <= 2'h3;
      IRQ            <= 1'b0;
      ctrl           <= debug_event_pkg::CTRL_RESET;
      status         <= debug_event_pkg::STATUS_RESET;
      mask           <= debug_event_pkg::MASK_RESET;
      aw_held        <= 1'b0;
      aw_addr        <= 4'h0;
      w_held         <= 1'b0;
      w_byte         <= 8'h00;
      w_lane0        <= 1'b0;
      S_AXI_BVALID   <= 1'b0;
      S_AXI_BRESP    <= 2'h0;
      S_AXI_RVALID   <= 1'b0;
      S_AXI_RDATA    <= 32'h0;
      S_AXI_RRESP    <= 2'h0;
    end else begin
      line_meta      <= EVT.bus_level;
      line_sync      <= line_meta;
      peer_meta      <= PEER_EVENT;
      peer_sync      <= peer_meta;
      gate_meta      <= EXT_COUNT_ACTIVE_GATE;
      gate_sync      <= gate_meta;
      EMULATOR_EVENT <= line_sync & peer_sync;
      IRQ            <= |(next_status & next_mask);
      ctrl           <= next_ctrl;
      status         <= next_status;
      mask           <= next_mask;
      aw_held        <= next_aw_held;
      aw_addr        <= next_aw_addr;
      w_held         <= next_w_held;
      w_byte         <= next_w_byte;
      w_lane0        <= next_w_lane0;
      S_AXI_BVALID   <= next_bvalid;
      S_AXI_BRESP    <= next_bresp;
      S_AXI_RVALID   <= next_rvalid;
      S_AXI_RDATA    <= next_rdata;
      S_AXI_RRESP    <= next_rresp;
    end
  end
endmodule : debug_event_glue
`default_nettype wire

// file: tb/debug_event_checker.sv
// Assertions on the event wiring between the device and the board glue.
`timescale 1ns/10ps
`default_nettype none
module debug_event_checker (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       EXT_COUNT_ACTIVE_GATE,
  input wire logic       HALTED,
  input wire logic [1:0] dev_pin_out,
  input wire logic [1:0] dev_pin_oe_n,
  input wire logic [1:0] dev_pin_in,
  input wire logic [1:0] bus_level,
  input wire logic [1:0] return_out,
  input wire logic [1:0] return_oe_n
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  logic [10:0] low_cnt;
  logic        armed;

  // Armed only drops during a pulse, so a second pulse needs the line high.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_cnt <= 11'h000;
      armed   <= 1'h1;
    end else begin
      low_cnt <= return_oe_n[0] ? 11'h000 : low_cnt + 11'h001;
      armed   <= bus_level[0] | (armed & return_oe_n[0]);
    end
  end

  sequence s_gate_held;
    EXT_COUNT_ACTIVE_GATE [*5];
  endsequence
  sequence s_pulse_start;
    $fell(return_oe_n[0]);
  endsequence

  property p_pulse_cause;
    s_pulse_start |-> $past(bus_level[0], 3) == 1'h0;
  endproperty
  property p_pulse_max;
    low_cnt <= 11'(debug_event_pkg::PULSE_CYCLES);
  endproperty
  property p_pulse_len;
    $rose(return_oe_n[0]) && !EXT_COUNT_ACTIVE_GATE
      |-> low_cnt == 11'(debug_event_pkg::PULSE_CYCLES);
  endproperty
  property p_gate_block;
    s_gate_held |-> return_oe_n == 2'h3;
  endproperty
  property p_open_drain;
    return_out == 2'h0;
  endproperty
  property p_rearm;
    s_pulse_start |-> armed;
  endproperty
  property p_idle_reset;
    $fell(SYS_RST) |-> dev_pin_oe_n == 2'h3;
  endproperty
  property p_sig_low;
    dev_pin_oe_n != 2'h0 |-> (dev_pin_out & ~dev_pin_oe_n) == 2'h0;
  endproperty
  property p_halt_cause;
    $rose(HALTED) |-> $past(dev_pin_in, 3) != 2'h3;
  endproperty

  a_pulse_cause: assert property (p_pulse_cause)
    else $error("return pulse without a low event line");
  a_pulse_max: assert property (p_pulse_max)
    else $error("return pulse too long");
  a_pulse_len: assert property (p_pulse_len)
    else $error("return pulse length wrong");
  a_gate_block: assert property (p_gate_block)
    else $error("return line pulled low while gated");
  a_open_drain: assert property (p_open_drain)
    else $error("return line driven high");
  a_rearm: assert property (p_rearm)
    else $error("second pulse without the line going high");
  a_idle_reset: assert property (p_idle_reset)
    else $error("event pins driven after reset");
  a_sig_low: assert property (p_sig_low)
    else $error("single driven pin not pulled low");
  a_halt_cause: assert property (p_halt_cause)
    else $error("halt without a low pin");
endmodule : debug_event_checker
`default_nettype wire

// file: tb/tb_debug_event_global_stop.sv
// Bench driving the device and glue ends joined by the event wiring.
`timescale 1ns/10ps
`default_nettype none
module tb_debug_event_global_stop;
  logic CLK = 1'h0;
  logic SYS_RST = 1'h1;
  debug_event_pkg::pin_mode_type pin_mode = debug_event_pkg::PIN_MODE_OFF;
  logic bench_run = 1'h0, halt_en = 1'h0, rel = 1'h0, tick = 1'h0;
  logic resume = 1'h0, gate = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
  logic arv = 1'h0, rready = 1'h0, halted, irq, awr, wr, bv, arr, rv;
  logic [1:0] req = 2'h0, peer = 2'h3, emu_evt, bresp, rresp;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdata, rd;
  logic [1:0] rr, br;
  int n_errors = 0, n_compared = 0;

  always #5 CLK = ~CLK;

  debug_event_if u_debug_event_if ();
  debug_event_device u_debug_event_device (.CLK(CLK), .SYS_RST(SYS_RST),
    .EVT(u_debug_event_if.device), .PIN_MODE(pin_mode),
    .BENCHMARK_RUN_COMMAND(bench_run), .HALT_ENABLE(halt_en),
    .EVENT_REQUEST(req), .EVENT_RELEASE(rel), .COUNT_TICK(tick),
    .RESUME(resume), .HALTED(halted));
  debug_event_glue u_debug_event_glue (.CLK(CLK), .SYS_RST(SYS_RST),
    .EVT(u_debug_event_if.glue), .EXT_COUNT_ACTIVE_GATE(gate),
    .PEER_EVENT(peer), .EMULATOR_EVENT(emu_evt), .IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
  debug_event_checker u_debug_event_checker (.CLK(CLK), .SYS_RST(SYS_RST),
    .EXT_COUNT_ACTIVE_GATE(gate), .HALTED(halted),
    .dev_pin_out(u_debug_event_if.dev_pin_out),
    .dev_pin_oe_n(u_debug_event_if.dev_pin_oe_n),
    .dev_pin_in(u_debug_event_if.dev_pin_in),
    .bus_level(u_debug_event_if.bus_level),
    .return_out(u_debug_event_if.return_out),
    .return_oe_n(u_debug_event_if.return_oe_n));

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc

  // Readies are sampled mid-cycle, where they have settled for the edge.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic ea, ew, hit;
    @(posedge CLK);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge CLK);
      ea = awv & awr;
      ew = wv & wr;
      @(posedge CLK);
      awv <= awv & ~ea;
      wv <= wv & ~ew;
    end while ((awv & ~ea) | (wv & ~ew));
    do begin
      @(negedge CLK);
      hit = bv;
      br = bresp;
      @(posedge CLK);
    end while (!hit);
    bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a);
    logic hit;
    @(posedge CLK);
    ara <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge CLK);
      hit = arr;
      @(posedge CLK);
    end while (!hit);
    arv <= 1'h0;
    do begin
      @(negedge CLK);
      hit = rv;
      rd = rdata;
      rr = rresp;
      @(posedge CLK);
    end while (!hit);
    rready <= 1'h0;
  endtask : axi_read

  task automatic wait_ret(input int ch, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (u_debug_event_if.return_level[ch] !== lvl && n < lim) begin
      @(negedge CLK);
      n++;
    end
  endtask : wait_ret

  task automatic pin_event(input logic [1:0] pins);
    @(posedge CLK);
    req <= pins;
    @(posedge CLK);
    req <= 2'h0;
  endtask : pin_event

  task automatic pin_release();
    @(posedge CLK);
    rel <= 1'h1;
    @(posedge CLK);
    rel <= 1'h0;
  endtask : pin_release

  task automatic t_reset_regs();
    logic [31:0] exp [4] = '{32'h0, 32'h0, 32'h0, 32'h3};
    for (int i = 0; i < 4; i++) begin
      axi_read(4'(i * 4));
      chk(rd, exp[i]);
    end
    axi_read(4'h2);
    chk(rr, debug_event_pkg::RESP_SLVERR);
    axi_write(4'h6, 32'h1);
    chk(br, debug_event_pkg::RESP_SLVERR);
    pin_event(2'h3);
    cyc(3);
    chk(u_debug_event_if.dev_pin_oe_n, 2'h3);
    $display("test reset_regs done");
  endtask : t_reset_regs

  task automatic t_signal_pulse();
    int n;
    axi_write(debug_event_pkg::MASK_OFFSET, 32'h1);
    chk(br, debug_event_pkg::RESP_OKAY);
    pin_mode <= debug_event_pkg::PIN_MODE_SIGNAL;
    pin_event(2'h1);
    @(negedge CLK);
    chk(u_debug_event_if.bus_level, 2'h2);
    wait_ret(0, 1'h0, 10, n);
    chk(n < 10, 1'h1);
    wait_ret(0, 1'h1, 1100, n);
    chk(n, debug_event_pkg::PULSE_CYCLES);
    chk(emu_evt, 2'h2);
    chk({irq, halted}, 2'h2);
    cyc(20);
    chk(u_debug_event_if.return_level, 2'h3);
    pin_release();
    cyc(2);
    chk(u_debug_event_if.bus_level, 2'h3);
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'h1);
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'h0);
    chk(irq, 1'h0);
    $display("test signal_pulse done");
  endtask : t_signal_pulse

  task automatic t_halt();
    int n;
    halt_en <= 1'h1;
    pin_event(2'h2);
    n = 0;
    while (halted !== 1'h1 && n < 8) begin
      @(negedge CLK);
      n++;
    end
    chk(halted, 1'h1);
    pin_release();
    wait_ret(1, 1'h1, 1100, n);
    cyc(4);
    chk(irq, 1'h0);
    @(posedge CLK);
    resume <= 1'h1;
    @(posedge CLK);
    resume <= 1'h0;
    halt_en <= 1'h0;
    cyc(2);
    chk(halted, 1'h0);
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'h2);
    $display("test halt done");
  endtask : t_halt

  task automatic t_gate();
    axi_write(debug_event_pkg::CTRL_OFFSET, 32'h1);
    axi_read(debug_event_pkg::LEVEL_OFFSET);
    chk(rd, 32'h13);
    pin_event(2'h1);
    cyc(8);
    chk(u_debug_event_if.return_level, 2'h3);
    pin_release();
    cyc(4);
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'h4);
    axi_write(debug_event_pkg::CTRL_OFFSET, 32'h0);
    $display("test gate done");
  endtask : t_gate

  task automatic t_peer();
    @(posedge CLK);
    peer <= 2'h1;
    cyc(5);
    chk(emu_evt, 2'h1);
    peer <= 2'h3;
    cyc(5);
    chk(emu_evt, 2'h3);
    $display("test peer done");
  endtask : t_peer

  // Peers stay idle throughout, as outside sources must during a count.
  // Peers held idle.
  task automatic t_count();
    int n;
    pin_event(2'h1);
    cyc(10);
    gate <= 1'h1;
    cyc(4);
    chk(u_debug_event_if.return_level, 2'h3);
    pin_release();
    cyc(4);
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'h1);
    pin_mode <= debug_event_pkg::PIN_MODE_OFF;
    bench_run <= 1'h1;
    tick <= 1'h1;
    cyc(3);
    chk(u_debug_event_if.dev_pin_oe_n, 2'h0);
    chk(u_debug_event_if.dev_pin_out, 2'h0);
    n = 0;
    while (u_debug_event_if.dev_pin_out[1] !== 1'h1 && n < 70000) begin
      @(negedge CLK);
      n++;
    end
    chk(n > 65500 && n < 65540, 1'h1);
    @(negedge CLK);
    chk(u_debug_event_if.dev_pin_out[1], 1'h0);
    chk(u_debug_event_if.return_level, 2'h3);
    @(posedge CLK);
    bench_run <= 1'h0;
    tick <= 1'h0;
    pin_mode <= debug_event_pkg::PIN_MODE_COUNT;
    cyc(3);
    chk(u_debug_event_if.dev_pin_oe_n, 2'h0);
    pin_mode <= debug_event_pkg::PIN_MODE_OFF;
    cyc(4);
    gate <= 1'h0;
    axi_read(debug_event_pkg::STATUS_OFFSET);
    chk(rd, 32'hC);
    $display("test count done");
  endtask : t_count

  // The count test alone needs about 66000 cycles; allow 80000.
  initial begin
    #800000;
    n_errors++;
    stop_test();
  end

  initial begin
    cyc(4);
    SYS_RST <= 1'h0;
    t_reset_regs();
    t_signal_pulse();
    t_halt();
    t_gate();
    t_peer();
    t_count();
    stop_test();
  end
endmodule : tb_debug_event_global_stop
`default_nettype wire
